// ===== include/alv_defines.svh
// offsets, field positions and reset values of the shared-pin block
`ifndef ALV_DEFINES_SVH
`define ALV_DEFINES_SVH

// ****************************************************************
// register bus
// ****************************************************************
`define ALV_ADDR_W 8
`define ALV_DATA_W 32
`define ALV_OFS_CTRL 8'h00
`define ALV_OFS_STATUS 8'h04
`define ALV_OFS_MASK 8'h08
`define ALV_OFS_LCVCNT 8'h0C
`define ALV_OFS_EXZCNT 8'h10

// ****************************************************************
// control fields
// ****************************************************************
`define ALV_CTRL_W 4
`define ALV_CTRL_BUSEN 0
`define ALV_CTRL_MODE_LO 1
`define ALV_CTRL_MODE_HI 2
`define ALV_CTRL_FALL 3
`define ALV_CTRL_RST 4'h0

// ****************************************************************
// status and mask fields
// ****************************************************************
`define ALV_EVT_W 3
`define ALV_EVT_AISP 0
`define ALV_EVT_LCV 1
`define ALV_EVT_EXZ 2
`define ALV_EVT_RST 3'h0

// ****************************************************************
// counters
// ****************************************************************
`define ALV_CNT_W 16
`define ALV_CNT_MAX 16'hFFFF
`define ALV_CNT_RST 16'h0000

`endif

// ===== include/alv_pkg.sv
// types shared by the shared-pin block
package alv_pkg;

	typedef enum logic [1:0] {
		ALV_MODE_STS1,
		ALV_MODE_SINGLE,
		ALV_MODE_DUAL
	} alv_mode_e;

	// software control word, packed to match the control register
	typedef struct packed {
		logic sampleFalling;
		logic [1:0] lineMode;
		logic busEnable;
	} alv_ctrl_s;

	// one sampled line bit towards the framer
	typedef struct packed {
		logic valid;
		logic pos;
		logic neg;
	} alv_rx_s;

endpackage

// ===== src/alv_edge_sampler.sv
// synchroniser and edge sampler for a slow pin clock and its data
`timescale 1ns/1ps

module alv_edge_sampler #(
	parameter int W = 2
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic pinClock,
	input wire logic [W-1:0] pinData,
	input wire logic fallingEdge,
	output logic strobe,
	output logic [W-1:0] sampleData
);

	logic clkSync1;
	logic clkSync2;
	logic clkLast;
	logic [W-1:0] dataSync1;
	logic [W-1:0] dataSync2;
	logic next_strobe;
	logic [W-1:0] next_sampleData;

	// ****************************************************************
	// edge detect
	// ****************************************************************
	// data passes the same two stages as the clock, so it is still the
	// value that stood at the pin edge when the edge is seen here
	always_comb begin
		next_strobe = 1'b0;
		next_sampleData = sampleData;
		if (clkSync2 != clkLast && clkSync2 == !fallingEdge) begin
			next_strobe = 1'b1;
			next_sampleData = dataSync2;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			clkSync1 <= 1'b0;
			clkSync2 <= 1'b0;
			clkLast <= 1'b0;
			dataSync1 <= '0;
			dataSync2 <= '0;
			strobe <= 1'b0;
			sampleData <= '0;
		end else begin
			clkSync1 <= pinClock;
			clkSync2 <= clkSync1;
			clkLast <= clkSync2;
			dataSync1 <= pinData;
			dataSync2 <= dataSync1;
			strobe <= next_strobe;
			sampleData <= next_sampleData;
		end
	end

	a_edge_select: assert property (
		@(posedge clk) disable iff (!arst_n)
		strobe |-> $past(clkSync2) != $past(clkLast)
			&& $past(clkSync2) == !$past(fallingEdge)
			&& sampleData == $past(dataSync2))
		else $error("strobe not on the selected pin clock edge");

endmodule

// ===== src/alv_pin_mux.sv
// per-channel alarm / negative rail / violation shared input
// Function
// - bus enable, then line mode, choose role
// - sampled indicator declares path AIS defect
// - single rail: pin is violation input
// - violation samples bump LCV or EXCESS_ZEROS_COUNT counts
// - dual rail: pin is negative data rail
// - positive pin carries all or positive data
`timescale 1ns/1ps

`include "alv_defines.svh"

module alv_pin_mux (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [`ALV_ADDR_W-1:0] regAddr,
	input wire logic [`ALV_DATA_W-1:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [`ALV_DATA_W-1:0] regRdata,
	input wire logic channelClockPin,
	input wire logic positivePin,
	input wire logic sharedPin,
	output alv_pkg::alv_rx_s rxLine,
	output logic pathAisDeclared,
	output logic irq
);

	alv_pkg::alv_ctrl_s ctrl;
	alv_pkg::alv_ctrl_s next_ctrl;
	logic [`ALV_EVT_W-1:0] status;
	logic [`ALV_EVT_W-1:0] next_status;
	logic [`ALV_EVT_W-1:0] mask;
	logic [`ALV_EVT_W-1:0] next_mask;
	logic [`ALV_EVT_W-1:0] events;
	logic [`ALV_CNT_W-1:0] lcvCount;
	logic [`ALV_CNT_W-1:0] next_lcvCount;
	logic [`ALV_CNT_W-1:0] exzCount;
	logic [`ALV_CNT_W-1:0] next_exzCount;
	logic [`ALV_DATA_W-1:0] next_regRdata;
	alv_pkg::alv_rx_s next_rxLine;
	logic next_pathAisDeclared;
	logic strobe;
	logic [1:0] sample;
	logic edgeFalling;
	alv_pkg::alv_mode_e mode;
	logic wrCtrl;
	logic wrStatus;
	logic wrMask;
	logic wrLcv;
	logic wrExz;

	// ****************************************************************
	// pin sampling
	// ****************************************************************
	// the add bus latches on the falling clock edge; the line clock
	// edge is software's choice
	// edge from control
	assign edgeFalling = ctrl.busEnable ? 1'b1 : ctrl.sampleFalling;

	alv_edge_sampler #(
		.W(2)
	) u_sampler (
		.clk(clk),
		.arst_n(arst_n),
		.pinClock(channelClockPin),
		.pinData({sharedPin, positivePin}),
		.fallingEdge(edgeFalling),
		.strobe(strobe),
		.sampleData(sample)
	);

	// an unused fourth code of the mode field behaves as STS-1
	always_comb begin
		unique case (ctrl.lineMode)
			2'h1: mode = alv_pkg::ALV_MODE_SINGLE;
			2'h2: mode = alv_pkg::ALV_MODE_DUAL;
			default: mode = alv_pkg::ALV_MODE_STS1;
		endcase
	end

	// ****************************************************************
	// role selection and line data
	// ****************************************************************
	always_comb begin
		events = '0;
		next_rxLine = '0;
		next_pathAisDeclared = 1'b0;
		if (strobe) begin
			if (ctrl.busEnable) begin
				if (sample[1]) begin
					events[`ALV_EVT_AISP] = 1'b1;
					next_pathAisDeclared = 1'b1;
				end
			end else begin
				next_rxLine.valid = 1'b1;
				next_rxLine.pos = sample[0];
				unique case (mode)
					alv_pkg::ALV_MODE_DUAL: begin
						next_rxLine.neg = sample[1];
					end
					alv_pkg::ALV_MODE_SINGLE: begin
						if (sample[1] && sample[0]) begin
							events[`ALV_EVT_LCV] = 1'b1;
						end else if (sample[1]) begin
							events[`ALV_EVT_EXZ] = 1'b1;
						end
					end
					alv_pkg::ALV_MODE_STS1: begin
						next_rxLine.neg = 1'b0;
					end
				endcase
			end
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	assign wrCtrl = regWrite && regAddr == `ALV_OFS_CTRL;
	assign wrStatus = regWrite && regAddr == `ALV_OFS_STATUS;
	assign wrMask = regWrite && regAddr == `ALV_OFS_MASK;
	assign wrLcv = regWrite && regAddr == `ALV_OFS_LCVCNT;
	assign wrExz = regWrite && regAddr == `ALV_OFS_EXZCNT;

	always_comb begin
		next_ctrl = ctrl;
		next_mask = mask;
		next_status = status;
		next_lcvCount = lcvCount;
		next_exzCount = exzCount;
		if (wrCtrl) begin
			next_ctrl = regWdata[`ALV_CTRL_W-1:0];
		end
		if (wrMask) begin
			next_mask = regWdata[`ALV_EVT_W-1:0];
		end
		// a new event wins over a write-one clear in the same cycle
		if (wrStatus) begin
			next_status = status & ~regWdata[`ALV_EVT_W-1:0];
		end
		next_status = next_status | events;
		// any write clears a counter; a count in that cycle survives unless the counter stood at its maximum
		if (wrLcv) begin
			next_lcvCount = '0;
		end
		if (wrExz) begin
			next_exzCount = '0;
		end
		if (events[`ALV_EVT_LCV] && lcvCount != `ALV_CNT_MAX) begin
			next_lcvCount = wrLcv ? `ALV_CNT_W'(1) : lcvCount + 1'b1;
		end
		if (events[`ALV_EVT_EXZ] && exzCount != `ALV_CNT_MAX) begin
			next_exzCount = wrExz ? `ALV_CNT_W'(1) : exzCount + 1'b1;
		end
	end

	// read data stand for one cycle only, zero otherwise
	always_comb begin
		next_regRdata = '0;
		if (regRead) begin
			unique case (regAddr)
				`ALV_OFS_CTRL: next_regRdata = `ALV_DATA_W'(ctrl);
				`ALV_OFS_STATUS: next_regRdata = `ALV_DATA_W'(status);
				`ALV_OFS_MASK: next_regRdata = `ALV_DATA_W'(mask);
				`ALV_OFS_LCVCNT: next_regRdata = `ALV_DATA_W'(lcvCount);
				`ALV_OFS_EXZCNT: next_regRdata = `ALV_DATA_W'(exzCount);
				default: next_regRdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl <= `ALV_CTRL_RST;
			mask <= `ALV_EVT_RST;
			status <= `ALV_EVT_RST;
			lcvCount <= `ALV_CNT_RST;
			exzCount <= `ALV_CNT_RST;
			regRdata <= '0;
			rxLine <= '0;
			pathAisDeclared <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			mask <= next_mask;
			status <= next_status;
			lcvCount <= next_lcvCount;
			exzCount <= next_exzCount;
			regRdata <= next_regRdata;
			rxLine <= next_rxLine;
			pathAisDeclared <= next_pathAisDeclared;
		end
	end

	assign irq = |(status & mask);

	// ****************************************************************
	// checks
	// ****************************************************************
	a_ais_declare: assert property (
		@(posedge clk) disable iff (!arst_n)
		strobe && ctrl.busEnable && sample[1]
			|=> pathAisDeclared && status[`ALV_EVT_AISP])
		else $error("sampled indicator did not declare path AIS");

	a_bus_blocks_line: assert property (
		@(posedge clk) disable iff (!arst_n)
		strobe && ctrl.busEnable && !wrLcv && !wrExz |=> !rxLine.valid
			&& $stable(lcvCount) && $stable(exzCount))
		else $error("line role active while add bus enabled");

	a_lcv_count: assert property (
		@(posedge clk) disable iff (!arst_n)
		strobe && !ctrl.busEnable && mode == alv_pkg::ALV_MODE_SINGLE
			&& sample == 2'b11 && !wrLcv && lcvCount != `ALV_CNT_MAX
			|=> lcvCount == $past(lcvCount) + 1'b1)
		else $error("violation sample not counted as LCV");

	a_exz_count: assert property (
		@(posedge clk) disable iff (!arst_n)
		strobe && !ctrl.busEnable && mode == alv_pkg::ALV_MODE_SINGLE
			&& sample == 2'b10 && !wrExz && !wrLcv
			&& exzCount != `ALV_CNT_MAX
			|=> exzCount == $past(exzCount) + 1'b1
			&& $stable(lcvCount) && status[`ALV_EVT_EXZ])
		else $error("violation sample not counted as EXCESS_ZEROS_COUNT");

	a_neg_rail: assert property (
		@(posedge clk) disable iff (!arst_n)
		strobe && !ctrl.busEnable && mode == alv_pkg::ALV_MODE_DUAL
			|=> rxLine.valid && rxLine.neg == $past(sample[1]))
		else $error("negative rail not passed in dual rail mode");

	a_neg_quiet: assert property (
		@(posedge clk) disable iff (!arst_n)
		mode != alv_pkg::ALV_MODE_DUAL |=> !rxLine.neg)
		else $error("negative rail driven outside dual rail mode");

	a_pos_rail: assert property (
		@(posedge clk) disable iff (!arst_n)
		strobe && !ctrl.busEnable
			|=> rxLine.valid && rxLine.pos == $past(sample[0]))
		else $error("positive pin data not passed");

	a_read_count: assert property (
		@(posedge clk) disable iff (!arst_n)
		regRead && regAddr == `ALV_OFS_LCVCNT
			|=> regRdata == `ALV_DATA_W'($past(lcvCount)) ##1
			($past(regRead) || regRdata == '0))
		else $error("counter read data wrong or held too long");

endmodule

// ===== bench/alv_line_source.sv
// far-side model: line interface unit or add-bus source on the shared pins
`timescale 1ns/1ps

module alv_line_source (
	input wire logic run,
	input wire logic nextPos,
	input wire logic nextNeg,
	output logic lineClock,
	output logic posPin,
	output logic negPin
);
	// ****************************************************************
	// clock and data
	// ****************************************************************
	// data moves a quarter period after the rise, so either edge sees it
	// settled; the clock stands low between frames
	initial begin
		lineClock = 1'b0;
		posPin = 1'b0;
		negPin = 1'b0;
		forever begin
			if (run) begin
				lineClock = 1'b1;
				#50;
				posPin = nextPos;
				negPin = nextNeg;
				#50;
				lineClock = 1'b0;
				#100;
			end else begin
				#3;
			end
		end
	end
endmodule

// ===== bench/alv_pin_mux_test.sv
// self-checking bench of the shared alarm / rail / violation pin
`timescale 1ns/1ps

`include "alv_defines.svh"

module alv_pin_mux_test;
	logic clk, arst_n, regWrite, regRead, irq, pathAisDeclared;
	logic [7:0] regAddr;
	logic [31:0] regWdata, regRdata, seed;
	logic pinClock, posPin, negPin, run, nextPos, nextNeg;
	logic busOn, fall;
	logic [1:0] mode;
	alv_pkg::alv_rx_s rxLine;
	logic [3:0] expQ[$];
	int error_cnt, num_checks, cycles, aisPend, aisSeen, lcvExp, exzExp;
	int aisExp;

	alv_pin_mux dut (.clk(clk), .arst_n(arst_n), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
		.regRdata(regRdata), .channelClockPin(pinClock),
		.positivePin(posPin), .sharedPin(negPin), .rxLine(rxLine),
		.pathAisDeclared(pathAisDeclared), .irq(irq));
	alv_line_source far (.run(run), .nextPos(nextPos), .nextNeg(nextNeg),
		.lineClock(pinClock), .posPin(posPin), .negPin(negPin));

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// bit 3 says whether the neg field is defined in this mode
	function automatic logic [3:0] expect_rx(input logic [1:0] md,
		input logic p, input logic n);
		if (md == alv_pkg::ALV_MODE_DUAL)
			return {1'b1, 1'b1, p, n};
		return {md != alv_pkg::ALV_MODE_SINGLE, 1'b1, p, 1'b0};
	endfunction

	task automatic chk32(input logic [31:0] e, input logic [31:0] a);
		num_checks++;
		if (a !== e) begin
			error_cnt++;
			$display("wrong value at %0t: exp %h got %h", $time, e, a);
		end
	endtask

	task automatic chk_rx(input logic [3:0] e, input alv_pkg::alv_rx_s a);
		logic [2:0] m;
		m = e[3] ? 3'h7 : 3'h6;
		chk32({29'h0, e[2:0] & m}, {29'h0, 3'(a) & m});
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'b0;
		#1;
		chk32(e, regRdata);
	endtask

	task automatic cfg(input logic b, input logic [1:0] md, input logic f);
		busOn = b;
		mode = md;
		fall = f;
		wr(`ALV_OFS_CTRL, {28'h0, f, md, b});
	endtask

	task automatic stream(input int n);
		run <= 1'b1;
		repeat (n) begin
			@(posedge pinClock);
			seed = lfsr(seed);
			nextPos = seed[0];
			// indicator pulses, pin low in STS-1
			if (busOn)
				nextNeg = seed[1] & seed[2];
			else
				nextNeg = seed[1] & (mode == 2'h1 || mode == 2'h2);
		end
		run <= 1'b0;
		nextNeg = 1'b0;
		repeat (24) @(posedge clk);
		chk32(32'(expQ.size() + aisPend), 32'h0);
	endtask

	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ****************************************************************
	// scoreboard
	// ****************************************************************
	always @(posedge pinClock or negedge pinClock) begin
		if (busOn && !pinClock && negPin) begin
			aisPend++;
			aisExp++;
		end
		if (!busOn && (pinClock ^ fall)) begin
			expQ.push_back(expect_rx(mode, posPin, negPin));
			if (mode == alv_pkg::ALV_MODE_SINGLE && negPin) begin
				if (posPin)
					lcvExp++;
				else
					exzExp++;
			end
		end
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 10000) begin
			error_cnt++;
			wrap_up();
		end
		if (pathAisDeclared === 1'b1) begin
			aisPend--;
			aisSeen++;
		end
		if (rxLine.valid === 1'b1) begin
			if (expQ.size() == 0)
				chk32(32'h0, 32'h1);
			else
				chk_rx(expQ.pop_front(), rxLine);
		end
	end

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		{arst_n, regWrite, regRead, regAddr, regWdata} = '0;
		{run, nextPos, nextNeg, busOn, fall, mode} = '0;
		seed = 32'h9AB5;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		// reset values, 0x14 is unmapped
		for (int a = 0; a <= 8'h14; a += 4)
			rd(8'(a), 32'h0);
		for (int m = 0; m < 8; m++) begin
			cfg(1'b0, 2'(m >> 1), m[0]);
			stream(24);
			rd(`ALV_OFS_LCVCNT, 32'(lcvExp));
			rd(`ALV_OFS_EXZCNT, 32'(exzExp));
			rd(`ALV_OFS_STATUS, {29'h0, exzExp != 0, lcvExp != 0, 1'b0});
			wr(`ALV_OFS_LCVCNT, 32'h0);
			wr(`ALV_OFS_EXZCNT, 32'h0);
			wr(`ALV_OFS_STATUS, 32'h7);
			lcvExp = 0;
			exzExp = 0;
		end
		rd(`ALV_OFS_LCVCNT, 32'h0);
		// a reset in mid-run must clear what software wrote
		wr(`ALV_OFS_MASK, 32'h7);
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		rd(`ALV_OFS_MASK, 32'h0);
		// indicator on the add bus, interrupt masked first
		wr(`ALV_OFS_MASK, 32'h0);
		cfg(1'b1, 2'h1, 1'b0);
		stream(24);
		chk32(32'(aisExp), 32'(aisSeen));
		chk32(32'h0, {31'h0, irq});
		rd(`ALV_OFS_STATUS, {31'h0, aisExp != 0});
		wr(`ALV_OFS_MASK, 32'h1);
		#1;
		chk32({31'h0, aisExp != 0}, {31'h0, irq});
		wr(`ALV_OFS_STATUS, 32'h1);
		#1;
		chk32(32'h0, {31'h0, irq});
		wrap_up();
	end
endmodule
